// file: core/atc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_cfg.svh"

module atc_regs
    import atc_pkg::*;
(
    input wire logic clk, // Auxiliary clock, 25 MHz
    input wire logic rst, // Async reset, high
    input wire logic master_reset_pin, // FIFO and flag clear pin
    input wire logic spi_sck, // Serial clock pin
    input wire logic spi_cs_n, // Chip select pin, low
    input wire logic spi_si, // Serial data in pin
    output logic spi_so, // Serial data out
    input wire logic line_one, // Line receiver one level pin
    input wire logic line_zero, // Line receiver zero level pin
    input wire logic tx_dig_one, // Serializer one output
    input wire logic tx_dig_zero, // Serializer zero output
    input wire logic [31:0] rx_word, // Received word, ARINC bit k at k-1
    input wire logic rx_word_valid, // Received word strobe
    input wire logic label_enabled, // Label memory hit for rx_word
    input wire logic [5:0] rx_fifo_count, // Receive FIFO level
    input wire logic [31:0] rx_fifo_head, // Receive FIFO head word
    input wire logic [5:0] tx_fifo_count, // Transmit FIFO level
    input wire logic [31:0] tx_fifo_head, // Transmit FIFO head, host order
    output logic rx_one, // Receiver one input
    output logic rx_zero, // Receiver zero input
    output logic tx_line_one, // Line driver one
    output logic tx_line_zero, // Line driver zero
    output logic rx_fifo_load, // Push strobe
    output logic [31:0] rx_fifo_wdata, // Word to push
    output logic rx_parity_error, // Parity fault on any received word strobe, pushed or not
    output logic rx_fifo_pop, // Pop strobe
    output logic fifo_clear, // Clear both FIFOs
    output logic tx_fifo_clear, // Clear transmit FIFO
    output logic [31:0] tx_word_out, // Word for serializer
    output logic tx_enable, // Serializer may send
    output logic aclk_en, // ARINC clock enable
    output logic rx_bit_en, // Receive rate enable
    output logic tx_bit_en, // Transmit rate enable
    output logic [15:0] config_word, // Configuration word
    output logic [7:0] status_word, // FIFO status word
    output logic rx_fifo_flag_pin, // Receive flag
    output logic tx_fifo_flag_pin // Transmit flag
);

    atc_core_type s;
    atc_core_type n;
    atc_spi_if sif();
    logic div_ok;
    logic [3:0] div_last;
    logic [6:0] rx_last;
    logic [6:0] tx_last;
    logic lab_ok;
    logic dec_ok;
    logic [31:0] tw;

    // Swap label field between ARINC and host order
    function automatic logic [31:0] atc_map(input logic [31:0] w, input logic keep);
        logic [31:0] r;
        r = w;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = keep ? w[i] : w[7 - i];
        end
        return r;
    endfunction

    // ----------------------------------------
    // Serial port shifter
    // ----------------------------------------
    atc_spi_shifter u_shift (
        .clk(clk),
        .rst(rst),
        .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n),
        .spi_si(spi_si),
        .spi_so(spi_so),
        .sif(sif)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        n = s;
        div_ok = 1'b0;
        div_last = s.div_code[3:0] - 4'h1;
        rx_last = s.cfg[`ATC_RX_RATE_SELECT] ? `ATC_LS_LAST : `ATC_HS_LAST;
        tx_last = s.cfg[`ATC_TX_RATE_SELECT] ? `ATC_LS_LAST : `ATC_HS_LAST;
        n.one_s1 = line_one;
        n.one_s2 = s.one_s1;
        n.zero_s1 = line_zero;
        n.zero_s2 = s.zero_s1;
        n.mr_s1 = master_reset_pin;
        n.mr_s2 = s.mr_s1;
        n.ld = 1'b0;
        n.rx_pop = 1'b0;
        n.tx_clear = 1'b0;
        n.fifo_clear = s.mr_s2;

        // Go latch drops once the FIFO drains or is cleared
        if (tx_fifo_count == 6'h00 || s.fifo_clear || s.tx_clear)
        begin
            n.tx_go = 1'b0;
        end

        // Serial frame decode
        if (sif.frame_start)
        begin
            n.state = ATC_OPCODE;
            n.bit_cnt = 6'h00;
        end
        else if (sif.frame_end)
        begin
            n.state = ATC_IDLE;
        end
        else if (sif.bit_stb && s.state != ATC_IDLE)
        begin
            n.sh = {s.sh[14:0], sif.bit_val};
            n.bit_cnt = s.bit_cnt + 6'h01;
            case (s.state)
                ATC_OPCODE:
                begin
                    if (n.bit_cnt == `ATC_OPC_END)
                    begin
                        n.state = ATC_IGNORE;
                        case (n.sh[7:0])
                            `ATC_OP_WR_CFG: n.state = ATC_WR_CFG;
                            `ATC_OP_WR_DIV: n.state = ATC_WR_DIV;
                            `ATC_OP_RD_CFG:
                            begin
                                n.ld = 1'b1;
                                n.ld_word = {s.cfg, 16'h0000};
                            end
                            `ATC_OP_RD_STAT:
                            begin
                                n.ld = 1'b1;
                                n.ld_word = {s.status, 24'h000000};
                            end
                            `ATC_OP_RD_DIV:
                            begin
                                n.ld = 1'b1;
                                n.ld_word = {s.div_code, 24'h000000};
                            end
                            `ATC_OP_RD_RXW:
                            begin
                                n.ld = 1'b1;
                                n.rx_pop = ~s.status[0];
                                n.ld_word = s.status[0] ? 32'h00000000 :
                                    atc_map(rx_fifo_head, s.cfg[`ATC_LABEL_ORDER_SELECT]);
                            end
                            `ATC_OP_MRESET: n.fifo_clear = 1'b1;
                            `ATC_OP_TX_CLR: n.tx_clear = 1'b1;
                            `ATC_OP_TX_GO: n.tx_go = 1'b1;
                            default: n.state = ATC_IGNORE;
                        endcase
                    end
                end
                ATC_WR_CFG:
                begin
                    if (n.bit_cnt == `ATC_CFG_END)
                    begin
                        n.cfg = n.sh;
                        n.state = ATC_IGNORE;
                    end
                end
                ATC_WR_DIV:
                begin
                    if (n.bit_cnt == `ATC_DIV_END)
                    begin
                        n.div_code = n.sh[7:0];
                        n.state = ATC_IGNORE;
                    end
                end
                default: n.state = s.state;
            endcase
        end

        // ARINC clock enable from auxiliary clock
        case (s.div_code[3:0])
            4'h1, 4'h2, 4'h4, 4'h8, 4'ha: div_ok = 1'b1;
            default: div_ok = 1'b0;
        endcase
        if (!s.cfg[`ATC_CLOCK_SOURCE_SELECT])
        begin
            n.aclk_en = 1'b1;
            n.div_cnt = 4'h0;
        end
        else if (!div_ok)
        begin
            n.aclk_en = 1'b0;
            n.div_cnt = 4'h0;
        end
        else if (s.div_cnt >= div_last)
        begin
            n.aclk_en = 1'b1;
            n.div_cnt = 4'h0;
        end
        else
        begin
            n.aclk_en = 1'b0;
            n.div_cnt = s.div_cnt + 4'h1;
        end

        // Bit rate enables
        n.rx_bit_en = 1'b0;
        n.tx_bit_en = 1'b0;
        if (s.aclk_en)
        begin
            if (s.rx_cnt >= rx_last)
            begin
                n.rx_cnt = 7'h00;
                n.rx_bit_en = 1'b1;
            end
            else
            begin
                n.rx_cnt = s.rx_cnt + 7'h01;
            end
            if (s.tx_cnt >= tx_last)
            begin
                n.tx_cnt = 7'h00;
                n.tx_bit_en = 1'b1;
            end
            else
            begin
                n.tx_cnt = s.tx_cnt + 7'h01;
            end
        end

        // FIFO status and flag pins
        n.status = {2'b00,
            tx_fifo_count >= `ATC_FIFO_FULL,
            tx_fifo_count >= `ATC_FIFO_HALF,
            tx_fifo_count == 6'h00,
            rx_fifo_count >= `ATC_FIFO_FULL,
            rx_fifo_count >= `ATC_FIFO_HALF,
            rx_fifo_count == 6'h00};
        n.rx_flag = s.cfg[`ATC_RX_FLAG_SELECT] ? n.status[2] : n.status[0];
        n.tx_flag = s.cfg[`ATC_TX_FLAG_SELECT] ? n.status[5] : n.status[3];

        // Transmit start and word shaping
        n.tx_enable = (tx_fifo_count != 6'h00) &&
            (s.cfg[`ATC_AUTO_TRANSMIT_MODE] || s.tx_go);
        tw = atc_map(tx_fifo_head, s.cfg[`ATC_LABEL_ORDER_SELECT]);
        if (s.cfg[`ATC_TX_PARITY_INSERT])
        begin
            tw[31] = ~(^tw[30:0]) ^ s.cfg[`ATC_TX_PARITY_SENSE];
        end
        n.tx_word = tw;

        // Line driver and self test path
        n.tx_one = s.cfg[`ATC_DRIVER_DISABLE] ? 1'b0 : tx_dig_one;
        n.tx_zero = s.cfg[`ATC_DRIVER_DISABLE] ? 1'b0 : tx_dig_zero;
        n.rx_one = s.cfg[`ATC_LOOPBACK_N] ? s.one_s2 : tx_dig_one;
        n.rx_zero = s.cfg[`ATC_LOOPBACK_N] ? s.zero_s2 : tx_dig_zero;

        // Receive word acceptance
        lab_ok = ~s.cfg[`ATC_LABEL_FILTER_ENABLE] | label_enabled;
        dec_ok = ~s.cfg[`ATC_RX_DECODER_ENABLE] |
            ((rx_word[9] == s.cfg[`ATC_MATCH_BIT_TEN]) &&
            (rx_word[8] == s.cfg[`ATC_MATCH_BIT_NINE]));
        n.rx_load = rx_word_valid & lab_ok & dec_ok;
        n.rx_par_err = rx_word_valid & s.cfg[`ATC_RX_PARITY_CHECK_ENABLE] & ~(^rx_word);
        n.rx_wdata = rx_word;
        if (s.cfg[`ATC_RX_PARITY_CHECK_ENABLE])
        begin
            n.rx_wdata[31] = ~(^rx_word);
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.state <= ATC_IDLE;
            s.cfg <= `ATC_CFG_RESET;
            s.div_code <= `ATC_DIV_RESET;
            s.status <= `ATC_STAT_RESET;
            s.rx_flag <= 1'b1;
            s.tx_flag <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    // Outputs straight from state
    assign sif.load = s.ld;
    assign sif.load_word = s.ld_word;
    assign rx_one = s.rx_one;
    assign rx_zero = s.rx_zero;
    assign tx_line_one = s.tx_one;
    assign tx_line_zero = s.tx_zero;
    assign rx_fifo_load = s.rx_load;
    assign rx_fifo_wdata = s.rx_wdata;
    assign rx_parity_error = s.rx_par_err;
    assign rx_fifo_pop = s.rx_pop;
    assign fifo_clear = s.fifo_clear;
    assign tx_fifo_clear = s.tx_clear;
    assign tx_word_out = s.tx_word;
    assign tx_enable = s.tx_enable;
    assign aclk_en = s.aclk_en;
    assign rx_bit_en = s.rx_bit_en;
    assign tx_bit_en = s.tx_bit_en;
    assign config_word = s.cfg;
    assign status_word = s.status;
    assign rx_fifo_flag_pin = s.rx_flag;
    assign tx_fifo_flag_pin = s.tx_flag;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_UNUSED_ZERO: assert property (status_word[7:6] == 2'b00)
        else $error("status unused bits not zero");
    AST_RX_EMPTY: assert property ((rx_fifo_count == 6'h00) && !config_word[15]
        |=> status_word[0] && rx_fifo_flag_pin)
        else $error("rx empty not shown");
    AST_RX_HALF: assert property (status_word[1] == ($past(rx_fifo_count) >= 6'h10))
        else $error("rx half bit wrong");
    AST_TX_FULL: assert property ((tx_fifo_count == 6'h20) && config_word[14]
        |=> status_word[5] && tx_fifo_flag_pin)
        else $error("tx full not shown");
    AST_DRIVER_NULL: assert property (config_word[12] |=> !tx_line_one && !tx_line_zero)
        else $error("driver not null");
    AST_TX_PARITY: assert property ($past(config_word[3])
        |-> (^tx_word_out) == !$past(config_word[9]))
        else $error("tx parity sense wrong");
    AST_DECODE: assert property (rx_fifo_load && $past(config_word[6])
        |-> $past(rx_word[9]) == $past(config_word[7]) && $past(rx_word[8]) == $past(config_word[8]))
        else $error("decoder mismatch stored");
    AST_LABEL: assert property (rx_fifo_load |-> $past(rx_word_valid)
        && (!$past(config_word[2]) || $past(label_enabled)))
        else $error("word stored without label hit");
    AST_TX_WAIT: assert property (!config_word[13] && !s.tx_go |=> !tx_enable)
        else $error("transmit without start");
    AST_LOOPBACK: assert property (!config_word[5] |=> rx_one == $past(tx_dig_one))
        else $error("self test path wrong");

endmodule

`default_nettype wire

// file: pkg/atc_cfg.svh
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH

// ----------------------------------------
// Serial instruction codes
// ----------------------------------------
`define ATC_OP_MRESET 8'h01
`define ATC_OP_WR_DIV 8'h07
`define ATC_OP_RD_RXW 8'h08
`define ATC_OP_RD_STAT 8'h0a
`define ATC_OP_RD_CFG 8'h0b
`define ATC_OP_RD_DIV 8'h0c
`define ATC_OP_WR_CFG 8'h10
`define ATC_OP_TX_CLR 8'h11
`define ATC_OP_TX_GO 8'h12

// ----------------------------------------
// Frame bit counts (opcode plus data)
// ----------------------------------------
`define ATC_OPC_END 6'h08
`define ATC_DIV_END 6'h10
`define ATC_CFG_END 6'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATC_CFG_RESET 16'h0000
`define ATC_DIV_RESET 8'h01
`define ATC_STAT_RESET 8'h09

// ----------------------------------------
// Configuration word bit positions
// ----------------------------------------
`define ATC_RX_RATE_SELECT 0
`define ATC_CLOCK_SOURCE_SELECT 1
`define ATC_LABEL_FILTER_ENABLE 2
`define ATC_TX_PARITY_INSERT 3
`define ATC_RX_PARITY_CHECK_ENABLE 4
`define ATC_LOOPBACK_N 5
`define ATC_RX_DECODER_ENABLE 6
`define ATC_MATCH_BIT_TEN 7
`define ATC_MATCH_BIT_NINE 8
`define ATC_TX_PARITY_SENSE 9
`define ATC_TX_RATE_SELECT 10
`define ATC_LABEL_ORDER_SELECT 11
`define ATC_DRIVER_DISABLE 12
`define ATC_AUTO_TRANSMIT_MODE 13
`define ATC_TX_FLAG_SELECT 14
`define ATC_RX_FLAG_SELECT 15

// ----------------------------------------
// FIFO levels and bit rate terminal counts
// ----------------------------------------
`define ATC_FIFO_HALF 6'h10
`define ATC_FIFO_FULL 6'h20
`define ATC_HS_LAST 7'h09
`define ATC_LS_LAST 7'h4f

`endif

// file: pkg/atc_pkg.sv
package atc_pkg;

    // Serial frame decoder states
    typedef enum logic [2:0] {
        ATC_IDLE,
        ATC_OPCODE,
        ATC_WR_CFG,
        ATC_WR_DIV,
        ATC_IGNORE
    } atc_state_type;

    // Register bank state
    typedef struct packed {
        logic one_s1;
        logic one_s2;
        logic zero_s1;
        logic zero_s2;
        logic mr_s1;
        logic mr_s2;
        atc_state_type state;
        logic [5:0] bit_cnt;
        logic [15:0] sh;
        logic [15:0] cfg;
        logic [7:0] div_code;
        logic [3:0] div_cnt;
        logic aclk_en;
        logic [6:0] rx_cnt;
        logic [6:0] tx_cnt;
        logic rx_bit_en;
        logic tx_bit_en;
        logic [7:0] status;
        logic rx_flag;
        logic tx_flag;
        logic tx_go;
        logic tx_enable;
        logic rx_pop;
        logic fifo_clear;
        logic tx_clear;
        logic rx_load;
        logic rx_par_err;
        logic [31:0] rx_wdata;
        logic [31:0] tx_word;
        logic tx_one;
        logic tx_zero;
        logic rx_one;
        logic rx_zero;
        logic ld;
        logic [31:0] ld_word;
    } atc_core_type;

    // Serial shifter state
    typedef struct packed {
        logic sck1;
        logic sck2;
        logic sck3;
        logic cs1;
        logic cs2;
        logic cs3;
        logic si1;
        logic si2;
        logic [31:0] sh;
        logic so;
        logic bit_stb;
        logic bit_val;
        logic fstart;
        logic fend;
    } atc_shift_type;

endpackage

// file: pkg/atc_spi_if.sv
`timescale 1ns/1ps
`default_nettype none

// Bits in from the serial port, words out to it
interface atc_spi_if;
    logic bit_stb;
    logic bit_val;
    logic frame_start;
    logic frame_end;
    logic load;
    logic [31:0] load_word;

    modport shifter (output bit_stb, bit_val, frame_start, frame_end, input load, load_word);
    modport core (input bit_stb, bit_val, frame_start, frame_end, output load, load_word);
endinterface

`default_nettype wire

// file: core/atc_spi_shifter.sv
`timescale 1ns/1ps
`default_nettype none

module atc_spi_shifter
    import atc_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic spi_sck, // Serial clock pin
    input wire logic spi_cs_n, // Chip select pin, low
    input wire logic spi_si, // Serial data in pin
    output logic spi_so, // Serial data out
    atc_spi_if.shifter sif // Bit and word carrier
);

    atc_shift_type s;
    atc_shift_type n;
    logic rise;
    logic fall;

    // ----------------------------------------
    // Pin sync, edge detect, output shift
    // ----------------------------------------
    always_comb
    begin
        n = s;
        n.sck1 = spi_sck;
        n.sck2 = s.sck1;
        n.sck3 = s.sck2;
        n.cs1 = spi_cs_n;
        n.cs2 = s.cs1;
        n.cs3 = s.cs2;
        n.si1 = spi_si;
        n.si2 = s.si1;
        rise = s.sck2 & ~s.sck3 & ~s.cs2;
        fall = ~s.sck2 & s.sck3 & ~s.cs2;
        n.bit_stb = rise;
        n.bit_val = s.si2;
        n.fstart = ~s.cs2 & s.cs3;
        n.fend = s.cs2 & ~s.cs3;
        if (sif.load)
        begin
            n.sh = sif.load_word;
        end
        else if (fall)
        begin
            n.so = s.sh[31]; // MSB first on falling edge
            n.sh = {s.sh[30:0], 1'b0};
        end
        if (s.cs2)
        begin
            n.so = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.sck1 <= 1'b0;
            s.cs1 <= 1'b1;
            s.cs2 <= 1'b1;
            s.cs3 <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign spi_so = s.so;
    assign sif.bit_stb = s.bit_stb;
    assign sif.bit_val = s.bit_val;
    assign sif.frame_start = s.fstart;
    assign sif.frame_end = s.fend;

endmodule

`default_nettype wire

// file: bench/atc_spi_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host on the serial port: mode 0, MSB first, slow clock
module atc_spi_host (
    input wire logic clk, // System clock
    output logic spi_sck, // Serial clock
    output logic spi_cs_n, // Chip select, low
    output logic spi_si, // Data to device
    input wire logic spi_so // Data from device
);
    // Idle bus, select off
    initial
    begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end

    // One frame: opcode then n data bits both ways
    task automatic xfer(input logic [7:0] op, input logic [31:0] wd, input int n,
                        output logic [31:0] rd);
        logic [39:0] sh;
        sh = {op, wd << (32 - n)};
        rd = 32'h0;
        @(posedge clk);
        spi_cs_n <= 1'b0;
        for (int i = 0; i < 8 + n; i++)
        begin
            spi_si <= sh[39 - i];
            repeat (8) @(posedge clk);
            if (i >= 8)
                rd = {rd[30:0], spi_so};
            spi_sck <= 1'b1;
            repeat (8) @(posedge clk);
            spi_sck <= 1'b0;
        end
        repeat (8) @(posedge clk);
        spi_cs_n <= 1'b1;
        spi_si <= 1'b0; // Pull-down level once released
        repeat (8) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// file: bench/arinc_terminal_ctrl_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module arinc_terminal_ctrl_status_regs_test;
    typedef struct packed {
        logic [15:0] cfg;
        logic [5:0] rxc;
        logic [5:0] txc;
        logic [7:0] st;
        logic rf;
        logic tf;
    } atc_row_type;
    atc_row_type rows [5] = '{'{16'h0000, 6'h00, 6'h00, 8'h09, 1'b1, 1'b1},
        '{16'hc000, 6'h20, 6'h20, 8'h36, 1'b1, 1'b1}, '{16'h4fa5, 6'h10, 6'h0f, 8'h02, 1'b0, 1'b0},
        '{16'h8000, 6'h00, 6'h10, 8'h11, 1'b0, 1'b0}, '{16'h3fff, 6'h20, 6'h00, 8'h0e, 1'b0, 1'b1}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mrp = 1'b0;
    logic line_one = 1'b0;
    logic tx_dig_one = 1'b0;
    logic rx_word_valid = 1'b0;
    logic label_enabled = 1'b0;
    logic [31:0] rx_word = 32'h0;
    logic [31:0] head = 32'h1234_5601;
    wire logic txen, rbe;
    logic [5:0] rxc = 6'h0;
    logic [5:0] txc = 6'h0;
    wire logic sck, cs_n, si, so, rx_one, tx_line_one, load, rf, tf;
    wire logic [15:0] config_word;
    wire logic [7:0] status_word;
    logic [31:0] rd;
    int n_mismatch = 0;
    int tests_run = 0;

    // Design and host
    atc_regs u_dut (.clk(clk), .rst(rst), .master_reset_pin(mrp), .spi_sck(sck),
        .spi_cs_n(cs_n), .spi_si(si), .spi_so(so), .line_one(line_one), .line_zero(1'b0),
        .tx_dig_one(tx_dig_one), .tx_dig_zero(1'b0), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .label_enabled(label_enabled), .rx_fifo_count(rxc),
        .rx_fifo_head(head), .tx_fifo_count(txc), .tx_fifo_head(32'h0), .rx_one(rx_one),
        .rx_zero(), .tx_line_one(tx_line_one), .tx_line_zero(), .rx_fifo_load(load),
        .rx_fifo_wdata(), .rx_parity_error(), .rx_fifo_pop(), .fifo_clear(), .tx_fifo_clear(),
        .tx_word_out(), .tx_enable(txen), .aclk_en(), .rx_bit_en(rbe), .tx_bit_en(),
        .config_word(config_word), .status_word(status_word), .rx_fifo_flag_pin(rf),
        .tx_fifo_flag_pin(tf));
    atc_spi_host u_host (.clk(clk), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so));

    // Clock
    always #20 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Count receive rate pulses over a span
    task automatic rate(input int span, input logic [31:0] exp);
        int c;
        c = 0;
        repeat (span)
        begin
            @(posedge clk);
            #1 c += rbe;
        end
        chk(c, exp);
    endtask

    // One received word, then the push strobe
    task automatic rx(input logic [31:0] w, input logic l, input logic e);
        @(posedge clk);
        rx_word <= w;
        label_enabled <= l;
        rx_word_valid <= 1'b1;
        @(posedge clk);
        rx_word_valid <= 1'b0;
        #1 chk(load, e);
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 chk(status_word, 8'h09);
        chk({rf, tf, config_word}, 18'h30000);
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            u_host.xfer(8'h10, rows[i].cfg, 16, rd);
            rxc <= rows[i].rxc;
            txc <= rows[i].txc;
            repeat (3) @(posedge clk);
            #1 chk(config_word, rows[i].cfg);
            chk(status_word, rows[i].st);
            chk({rf, tf}, {rows[i].rf, rows[i].tf});
            u_host.xfer(8'h0b, 32'h0, 16, rd);
            chk(rd, rows[i].cfg);
            u_host.xfer(8'h0a, 32'h0, 8, rd);
            chk(rd, rows[i].st);
        end
        rxc <= 6'h0;
        u_host.xfer(8'h08, 32'h0, 32, rd);
        chk(rd, 32'h0);
        tx_dig_one <= 1'b1;
        u_host.xfer(8'h10, 32'h1000, 16, rd);
        repeat (4) @(posedge clk);
        #1 chk({tx_line_one, rx_one}, 2'b01);
        u_host.xfer(8'h10, 32'h0020, 16, rd);
        repeat (4) @(posedge clk);
        #1 chk({tx_line_one, rx_one}, 2'b10);
        rxc <= 6'h01;
        u_host.xfer(8'h0a, 32'h0, 8, rd);
        chk(rd, 32'h08);
        u_host.xfer(8'h08, 32'h0, 32, rd);
        chk(rd, 32'h1234_5680);
        rxc <= 6'h00;
        rate(100, 10);
        txc <= 6'h01;
        repeat (3) @(posedge clk);
        #1 chk(txen, 1'b0);
        u_host.xfer(8'h12, 32'h0, 0, rd);
        #1 chk(txen, 1'b1);
        txc <= 6'h00;
        repeat (3) @(posedge clk);
        #1 chk(txen, 1'b0);
        u_host.xfer(8'h10, 32'h0021, 16, rd);
        repeat (100) @(posedge clk);
        rate(800, 10);
        u_host.xfer(8'h10, 32'h01e4, 16, rd);
        rx(32'h0000_0300, 1'b1, 1'b1);
        rx(32'h0000_0300, 1'b0, 1'b0);
        rx(32'h0000_0100, 1'b1, 1'b0);
        rx(32'h0000_0200, 1'b1, 1'b0);
        end_sim();
    end

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule

`default_nettype wire
